// *** rtl/cces_consts.svh ***
`ifndef CCES_CONSTS_SVH
`define CCES_CONSTS_SVH
`define CCES_OFF_CTL 8'h00
`define CCES_OFF_STAT 8'h08
`define CCES_OFF_MASK 8'h0c
`define CCES_OFF_DRR 8'h10
`define CCES_OFF_DXR 8'h14
`define CCES_OFF_CMD 8'h30
`define CCES_BIT_CCS 13
`define CCES_BIT_TRN 12
`define CCES_BIT_DAT3 11
`define CCES_BIT_RXRDY 10
`define CCES_BIT_TXRDY 9
`define CCES_BIT_DATDONE 0
`define CCES_STAT_IMPL 32'h0000_3eff
`define CCES_STAT_RDY 32'h0000_0600
`define CCES_STAT_RESET 32'h0000_0200
`define CCES_CTL_DPRST 0
`define CCES_CTL_EDGE_LO 6
`define CCES_CTL_EDGE_HI 7
`define CCES_CMD_BUSYEXP 8
`define CCES_CMD_DATA_CLEAR_ON_COMMAND 16
`define CCES_EDGE_OFF 2'h0
`define CCES_EDGE_RISE 2'h1
`define CCES_EDGE_FALL 2'h2
`define CCES_EDGE_BOTH 2'h3
`endif

// *** rtl/cces_pkg.sv ***
package cces_pkg;
  typedef enum logic [1:0] {
    CCES_DP_IDLE = 2'b00,
    CCES_DP_XFER = 2'b01,
    CCES_DP_HOLD = 2'b10
  } cces_dp_state_t;
endpackage

// *** rtl/cces_top.sv ***
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cces_consts.svh"
module cces_top
  import cces_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic card_data_line_three,
  input wire logic ccs_done,
  input wire logic xfer_start,
  input wire logic xfer_last_byte,
  input wire logic data_finish,
  input wire logic busy_release,
  input wire logic [7:1] other_events,
  input wire logic rx_word_valid,
  input wire logic [31:0] rx_word,
  input wire logic tx_word_sent,
  output logic [31:0] tx_word,
  output logic tx_word_load,
  output logic cmd_issue,
  output logic [5:0] cmd_index,
  output logic cmd_busy_expected,
  output logic data_path_reset,
  output logic data_path_hold
);

  logic addr_ok;
  logic rd_stat;
  logic rd_drr;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic wr_ctl;
  logic wr_mask;
  logic wr_cmd;
  logic wr_dxr;
  logic [31:0] status;
  logic [31:0] next_status;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] mask;
  logic [1:0] dat3_edge_select;
  logic [31:0] rx_data;
  logic dat3_prev;
  logic dat3_hit;
  logic cmd_data_clear_on_command;
  cces_dp_state_t dp_state;
  logic [31:0] rd_value;

  // all checks below share the bus clock and are off while reset is asserted
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // address phase decode; hready gates it so a stalled phase is not taken twice
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_stat = addr_ok & ~hwrite & (haddr[7:0] == `CCES_OFF_STAT);
  assign rd_drr = addr_ok & ~hwrite & (haddr[7:0] == `CCES_OFF_DRR);
  assign wr_ctl = wr_pend & (wr_addr == `CCES_OFF_CTL);
  assign wr_mask = wr_pend & (wr_addr == `CCES_OFF_MASK);
  assign wr_cmd = wr_pend & (wr_addr == `CCES_OFF_CMD);
  assign wr_dxr = wr_pend & (wr_addr == `CCES_OFF_DXR);
  assign cmd_data_clear_on_command = wr_cmd & hwdata[`CCES_CMD_DATA_CLEAR_ON_COMMAND];

  // write address is held over into the data phase, where hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // zero wait states, always okay; unmapped offsets read zero and ignore writes
  always_comb begin
    unique case (haddr[7:0])
      `CCES_OFF_CTL: rd_value = {24'h000000, dat3_edge_select, 5'h00, data_path_reset};
      `CCES_OFF_STAT: rd_value = status & `CCES_STAT_IMPL;
      `CCES_OFF_MASK: rd_value = mask;
      `CCES_OFF_DRR: rd_value = rx_data;
      `CCES_OFF_DXR: rd_value = tx_word;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_ok & ~hwrite) ? rd_value : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dat3_edge_select <= `CCES_EDGE_OFF;
      data_path_reset <= 1'b0;
      mask <= 32'h0000_0000;
    end else begin
      if (wr_ctl) begin
        dat3_edge_select <= hwdata[`CCES_CTL_EDGE_HI:`CCES_CTL_EDGE_LO];
        data_path_reset <= hwdata[`CCES_CTL_DPRST];
      end
      if (wr_mask) begin
        mask <= hwdata & `CCES_STAT_IMPL;
      end
    end
  end

  // dat3 edge detection against the previous sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dat3_prev <= 1'b0;
    end else begin
      dat3_prev <= card_data_line_three;
    end
  end

  always_comb begin
    unique case (dat3_edge_select)
      `CCES_EDGE_RISE: dat3_hit = card_data_line_three & ~dat3_prev;
      `CCES_EDGE_FALL: dat3_hit = ~card_data_line_three & dat3_prev;
      `CCES_EDGE_BOTH: dat3_hit = card_data_line_three ^ dat3_prev;
      `CCES_EDGE_OFF: dat3_hit = 1'b0;
    endcase
  end

  // the flag appears one edge after the line change, so a read in that cycle cannot lose it
  a_dat3_rise: assert property (dat3_edge_select == `CCES_EDGE_RISE && $rose(card_data_line_three)
                                |=> status[`CCES_BIT_DAT3])
    else $error("rising dat3 edge not flagged");
  a_dat3_fall: assert property (dat3_edge_select == `CCES_EDGE_FALL && $fell(card_data_line_three)
                                |=> status[`CCES_BIT_DAT3])
    else $error("falling dat3 edge not flagged");
  a_dat3_off: assert property (dat3_edge_select == `CCES_EDGE_OFF && !status[`CCES_BIT_DAT3]
                               |=> !status[`CCES_BIT_DAT3])
    else $error("dat3 flag set while detection off");

  // set and clear vectors; a set in the clearing cycle wins so no event is lost
  always_comb begin
    set_v = 32'h0000_0000;
    set_v[`CCES_BIT_CCS] = ccs_done;
    set_v[`CCES_BIT_TRN] = xfer_last_byte;
    set_v[`CCES_BIT_DAT3] = dat3_hit;
    set_v[`CCES_BIT_RXRDY] = rx_word_valid;
    set_v[`CCES_BIT_TXRDY] = tx_word_sent | data_path_reset | cmd_data_clear_on_command;
    set_v[7:1] = other_events;
    set_v[`CCES_BIT_DATDONE] = data_finish;
    clr_v = 32'h0000_0000;
    if (rd_stat) begin
      clr_v = status & ~`CCES_STAT_RDY;
    end
    clr_v[`CCES_BIT_RXRDY] = data_path_reset | cmd_data_clear_on_command | rd_drr;
    clr_v[`CCES_BIT_TXRDY] = wr_dxr;
    next_status = ((status & ~clr_v) | set_v) & `CCES_STAT_IMPL;
  end

  // status writes are decoded nowhere, so they cannot touch a flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= `CCES_STAT_RESET;
    end else begin
      status <= next_status;
    end
  end

  // a status read clears what it read, but the word-ready pair only follows its own events
  sequence s_stat_read;
    rd_stat ##1 1'b1;
  endsequence

  a_read_clears_flag: assert property (rd_stat && !ccs_done && status[`CCES_BIT_CCS]
                                       |=> !status[`CCES_BIT_CCS])
    else $error("completion flag survived a status read");
  a_rdy_keep_read: assert property (s_stat_read |->
                                    status[`CCES_BIT_RXRDY] || !$past(status[`CCES_BIT_RXRDY])
                                    || $past(data_path_reset || cmd_data_clear_on_command || rd_drr))
    else $error("receive ready lost on a status read");
  a_rdy_read_hold: assert property (rd_stat && !rd_drr && !data_path_reset && !wr_cmd && !wr_dxr
                                    && !rx_word_valid && !tx_word_sent |=> $stable(status[10:9]))
    else $error("status read changed a word-ready flag");
  a_trn_set: assert property (xfer_last_byte |=> status[`CCES_BIT_TRN])
    else $error("transfer finished flag not set");
  a_done_set: assert property (data_finish |=> status[`CCES_BIT_DATDONE])
    else $error("data finished flag not set");
  a_reserved_zero: assert property ((status & ~`CCES_STAT_IMPL) == 32'h0000_0000)
    else $error("reserved status bit set");

  // interrupt is a registered level of any unmasked flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  // irq is built from the old mask, so a mask write shows one edge later
  a_irq_follows_mask: assert property (irq == |(status & $past(mask)))
    else $error("irq does not match the unmasked flags");

  // receive and transmit data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data <= 32'h0000_0000;
      tx_word <= 32'h0000_0000;
      tx_word_load <= 1'b0;
    end else begin
      if (rx_word_valid) begin
        rx_data <= rx_word;
      end
      if (wr_dxr) begin
        tx_word <= hwdata;
      end
      tx_word_load <= wr_dxr;
    end
  end

  // a new word arriving in the clearing cycle keeps receive ready set
  a_rx_clear: assert property (rd_drr && !rx_word_valid |=> !status[`CCES_BIT_RXRDY])
    else $error("receive ready not cleared by data read");
  a_rx_data_clear_on_command: assert property (cmd_data_clear_on_command && !rx_word_valid |=> !status[`CCES_BIT_RXRDY])
    else $error("receive ready not cleared by a data clear command");
  a_rx_set: assert property (rx_word_valid |=> status[`CCES_BIT_RXRDY] && rx_data == $past(rx_word))
    else $error("receive word not captured");
  a_tx_set: assert property (data_path_reset || tx_word_sent |=> status[`CCES_BIT_TXRDY])
    else $error("transmit ready not set");
  a_tx_data_clear_on_command: assert property (cmd_data_clear_on_command |=> status[`CCES_BIT_TXRDY])
    else $error("transmit ready not set by a data clear command");

  // command path runs whatever the data path state is
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_issue <= 1'b0;
      cmd_index <= 6'h00;
      cmd_busy_expected <= 1'b0;
    end else begin
      cmd_issue <= wr_cmd;
      if (wr_cmd) begin
        cmd_index <= hwdata[5:0];
        cmd_busy_expected <= hwdata[`CCES_CMD_BUSYEXP];
      end
    end
  end

  a_cmd_issue: assert property (wr_cmd |=> cmd_issue && cmd_index == $past(hwdata[5:0]))
    else $error("command not issued");
  a_cmd_single: assert property (!wr_cmd |=> !cmd_issue)
    else $error("command issued with no command write");

  // data path: a busy-expecting command during a transfer parks it until the card frees busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_state <= CCES_DP_IDLE;
    end else if (data_path_reset) begin
      dp_state <= CCES_DP_IDLE;
    end else begin
      unique case (dp_state)
        CCES_DP_IDLE: begin
          if (xfer_start) begin
            dp_state <= CCES_DP_XFER;
          end
        end
        CCES_DP_XFER: begin
          if (wr_cmd & hwdata[`CCES_CMD_BUSYEXP]) begin
            dp_state <= CCES_DP_HOLD;
          end else if (data_finish) begin
            dp_state <= CCES_DP_IDLE;
          end
        end
        CCES_DP_HOLD: begin
          if (busy_release) begin
            dp_state <= CCES_DP_IDLE;
          end
        end
        default: dp_state <= CCES_DP_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_path_hold <= 1'b0;
    end else begin
      data_path_hold <= (dp_state == CCES_DP_XFER) & wr_cmd & hwdata[`CCES_CMD_BUSYEXP] & ~data_path_reset
                        | (dp_state == CCES_DP_HOLD) & ~busy_release & ~data_path_reset;
    end
  end

  // a busy-expecting command parks the data path; any other command lets the transfer run on
  sequence s_busy_cmd;
    dp_state == CCES_DP_XFER && wr_cmd && hwdata[`CCES_CMD_BUSYEXP] && !data_path_reset;
  endsequence

  a_hold_enter: assert property (s_busy_cmd |=> data_path_hold && dp_state == CCES_DP_HOLD)
    else $error("data path did not hold for a busy command");
  a_hold_busy: assert property (dp_state == CCES_DP_XFER && wr_cmd && !hwdata[`CCES_CMD_BUSYEXP]
                                && !data_finish && !data_path_reset
                                |=> dp_state == CCES_DP_XFER && !data_path_hold)
    else $error("data path stopped for a command without busy");
  a_hold_release: assert property (dp_state == CCES_DP_HOLD && busy_release
                                   |=> dp_state == CCES_DP_IDLE && !data_path_hold)
    else $error("data path still held after busy release");

endmodule

// *** sim/card_ctrl_event_status_tb.sv ***
`timescale 1ns/1ps
`include "cces_consts.svh"
module card_ctrl_event_status_tb;
  import cces_pkg::*;
  logic hclk, hresetn, hsel, hwrite, card_data_line_three;
  logic [31:0] haddr, hwdata, hrdata, rx_word, tx_word, rd, rd_q, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, irq, tx_word_load, cmd_issue, cmd_busy_expected, data_path_reset, data_path_hold, rdy_q;
  logic [5:0] cmd_index;
  logic [13:0] ev;
  int bad_count, checked, cyc;
  // compare macro, four-state safe
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
  cces_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .card_data_line_three(card_data_line_three), .ccs_done(ev[0]), .xfer_start(ev[1]),
    .xfer_last_byte(ev[2]), .data_finish(ev[3]), .busy_release(ev[4]), .other_events(ev[13:7]),
    .rx_word_valid(ev[5]), .rx_word(rx_word), .tx_word_sent(ev[6]), .tx_word(tx_word),
    .tx_word_load(tx_word_load), .cmd_issue(cmd_issue), .cmd_index(cmd_index),
    .cmd_busy_expected(cmd_busy_expected), .data_path_reset(data_path_reset), .data_path_hold(data_path_hold));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // bus outputs copied mid-cycle so the rising edge sees them without a race
  always @(negedge hclk) begin
    rd_q = hrdata;
    rdy_q = hreadyout;
  end
  // hang guard; the whole sequence needs well under 2000 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // expected status from event pulses and the two ready levels
  function automatic logic [31:0] stat_exp(input logic [13:0] m, input logic tx, input logic rx);
    stat_exp = 32'h0;
    stat_exp[`CCES_BIT_CCS] = m[0];
    stat_exp[`CCES_BIT_TRN] = m[2];
    stat_exp[`CCES_BIT_DATDONE] = m[3];
    stat_exp[7:1] = m[13:7];
    stat_exp[`CCES_BIT_RXRDY] = rx;
    stat_exp[`CCES_BIT_TXRDY] = tx;
  endfunction
  // dat3 edge flag expected for a mode and a rising or falling change
  function automatic logic edge_exp(input logic [1:0] mode, input logic rise);
    edge_exp = rise ? mode[0] : mode[1];
  endfunction
  // single word transfer; waits on ready at both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (rdy_q !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (rdy_q !== 1'b1) @(posedge hclk);
    r = rd_q;
  endtask
  task automatic rd_stat(input logic [31:0] exp);
    bus(1'b0, `CCES_OFF_STAT, 32'h0, rd);
    `CHK(rd, exp)
  endtask
  task automatic fire(input logic [13:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 14'h0;
  endtask
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [13:0] m;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    card_data_line_three = 1'b0;
    ev = 14'h0;
    rx_word = 32'h0;
    void'($urandom(32'hd9a5));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_stat(32'h0000_0200);
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    // completion, transfer and data-done events at once, random error bits; a second read sees only ready flags
    m = {7'($urandom()), 7'b0001101};
    fire(m);
    rd_stat(stat_exp(m, 1'b1, 1'b0));
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    // receive word: ready survives status reads, read of the data clears it
    rx_word <= $urandom();
    fire(14'h0020);
    rd_stat(stat_exp(14'h0, 1'b1, 1'b1));
    rd_stat(stat_exp(14'h0, 1'b1, 1'b1));
    bus(1'b0, `CCES_OFF_DRR, 32'h0, rd);
    `CHK(rd, rx_word)
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    // transmit word: write clears ready, sent pulse sets it
    d = $urandom();
    bus(1'b1, `CCES_OFF_DXR, d, rd);
    @(negedge hclk);
    `CHK(tx_word_load, 1'b1)
    `CHK(tx_word, d)
    rd_stat(stat_exp(14'h0, 1'b0, 1'b0));
    fire(14'h0040);
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    // command with data clear: rx ready drops, tx ready rises
    bus(1'b1, `CCES_OFF_DXR, d, rd);
    fire(14'h0020);
    d = {15'h0, 1'b1, 7'h0, 1'b0, 2'h0, 6'($urandom())};
    bus(1'b1, `CCES_OFF_CMD, d, rd);
    @(negedge hclk);
    `CHK(cmd_issue, 1'b1)
    `CHK(cmd_index, d[5:0])
    `CHK(cmd_busy_expected, 1'b0)
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    // data path reset holds rx clear and tx set
    bus(1'b1, `CCES_OFF_CTL, 32'h1, rd);
    fire(14'h0020);
    bus(1'b1, `CCES_OFF_DXR, d, rd);
    `CHK(data_path_reset, 1'b1)
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    bus(1'b1, `CCES_OFF_CTL, 32'h0, rd);
    // status writes and unmapped reads
    bus(1'b1, `CCES_OFF_STAT, 32'hffff_ffff, rd);
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    bus(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0)
    // every dat3 edge select mode with a rise and a fall
    for (int mode = 0; mode < 4; mode++) begin
      bus(1'b1, `CCES_OFF_CTL, 32'(mode) << `CCES_CTL_EDGE_LO, rd);
      for (int e = 1; e >= 0; e--) begin
        @(posedge hclk);
        card_data_line_three <= e[0];
        repeat (4) @(posedge hclk);
        bus(1'b0, `CCES_OFF_STAT, 32'h0, rd);
        `CHK(rd[`CCES_BIT_DAT3], edge_exp(2'(mode), e[0]))
      end
    end
    rd_stat(stat_exp(14'h0, 1'b1, 1'b0));
    // interrupt: masked off, then enabled, then cleared by the read
    bus(1'b1, `CCES_OFF_MASK, 32'h0, rd);
    fire(14'h0001);
    repeat (2) @(negedge hclk);
    `CHK(irq, 1'b0)
    rd_stat(stat_exp(14'h0001, 1'b1, 1'b0));
    bus(1'b1, `CCES_OFF_MASK, 32'h1 << `CCES_BIT_CCS, rd);
    fire(14'h0001);
    repeat (2) @(negedge hclk);
    `CHK(irq, 1'b1)
    rd_stat(stat_exp(14'h0001, 1'b1, 1'b0));
    repeat (2) @(negedge hclk);
    `CHK(irq, 1'b0)
    // command during a transfer: hold only when busy is expected
    fire(14'h0002);
    bus(1'b1, `CCES_OFF_CMD, 32'h1 << `CCES_CMD_BUSYEXP, rd);
    repeat (3) @(negedge hclk);
    `CHK(cmd_busy_expected, 1'b1)
    `CHK(data_path_hold, 1'b1)
    fire(14'h0010);
    repeat (3) @(negedge hclk);
    `CHK(data_path_hold, 1'b0)
    fire(14'h0002);
    bus(1'b1, `CCES_OFF_CMD, 32'h0c, rd);
    repeat (3) @(negedge hclk);
    `CHK(data_path_hold, 1'b0)
    fire(14'h0008);
    rd_stat(stat_exp(14'h0008, 1'b1, 1'b0));
    complete_run();
  end
endmodule
